// [rsc_pkg.sv]
// Summary of operation
// (RULE_01) host waits 10 ms after power-on reset
// (RULE_02) host leaves reset pin undriven during POR
// (RULE_03) manual reset: 100 us high, wait 5 ms
// (RULE_04) device drives reset pin high during POR
// (RULE_05) clock output runs only when enabled
// (RULE_06) divider field sets clock output ratio
// (RULE_07) clock output on at power-up, off asleep
// (RULE_08) lock status sticky until written one
// (RULE_09) lock pin mirrors lock when enabled
// (RULE_10) lock pin enable latches on each lock
// (RULE_11) R within 64..169, P plus one above S; the host repair caps S at P instead
// (RULE_12) R near 119 recommended
// (RULE_13) band select coded per frequency band
// (RULE_14) VCO trim steps upward from 00
// (RULE_15) mode 100 selects transmit operation
// (RULE_16) disabled clock output held low
package rsc_pkg;
  // ---------------------------------------------
  // clock and link framing
  // ---------------------------------------------
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned SCK_HALF_CYC = 4;
  localparam int unsigned FRAME_BITS   = 16;
  // ---------------------------------------------
  // register offsets
  // ---------------------------------------------
  localparam logic [4:0] GCON_ADDR  = 5'h00;
  localparam logic [4:0] R1_ADDR    = 5'h06;
  localparam logic [4:0] P1_ADDR    = 5'h07;
  localparam logic [4:0] S1_ADDR    = 5'h08;
  localparam logic [4:0] R2_ADDR    = 5'h09;
  localparam logic [4:0] P2_ADDR    = 5'h0A;
  localparam logic [4:0] S2_ADDR    = 5'h0B;
  localparam logic [4:0] FTPRI_ADDR = 5'h0E;
  localparam logic [4:0] CLKO_ADDR  = 5'h1B;
  // ---------------------------------------------
  // field positions and codes
  // ---------------------------------------------
  localparam int unsigned MODE_LSB   = 5;
  localparam int unsigned BAND_LSB   = 3;
  localparam int unsigned TRIM_LSB   = 1;
  localparam int unsigned CLKEN_BIT  = 7;
  localparam int unsigned CLKDIV_LSB = 2;
  localparam int unsigned LOCK_STS   = 1;
  localparam int unsigned LOCK_PEN   = 0;
  localparam logic [2:0] MODE_SLEEP  = 3'h0;
  localparam logic [2:0] MODE_TX     = 3'h4;
  localparam logic [7:0] R_MIN       = 8'h40;
  localparam logic [7:0] R_MAX       = 8'hA9;
  localparam logic [7:0] R_RECOMMEND = 8'h77;
  localparam logic [1:0] TRIM_START  = 2'h0;
  // ---------------------------------------------
  // reset values
  // ---------------------------------------------
  localparam logic [7:0] GCON_RST  = 8'h20;
  localparam logic [7:0] R1_RST    = 8'h77;
  localparam logic [7:0] P1_RST    = 8'h64;
  localparam logic [7:0] S1_RST    = 8'h32;
  localparam logic [7:0] R2_RST    = 8'h74;
  localparam logic [7:0] P2_RST    = 8'h62;
  localparam logic [7:0] S2_RST    = 8'h32;
  localparam logic [7:0] FTPRI_RST = 8'h01;
  localparam logic [7:0] CLKO_RST  = 8'hBC;
  // ---------------------------------------------
  // timing
  // ---------------------------------------------
  localparam int unsigned POR_WAIT_MS   = 10;
  localparam int unsigned MRST_PULSE_US = 100;
  localparam int unsigned MRST_WAIT_MS  = 5;
  localparam int unsigned DEV_POR_US    = 100;
  localparam int unsigned POR_WAIT_CYC  = POR_WAIT_MS * (CLK_HZ / 1000);
  localparam int unsigned MRST_PULSE_CYC =
    MRST_PULSE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned MRST_WAIT_CYC = MRST_WAIT_MS * (CLK_HZ / 1000);
  localparam int unsigned DEV_POR_CYC   = DEV_POR_US * (CLK_HZ / 1_000_000);

  function automatic logic [7:0] reset_value(input logic [4:0] a);
    unique case (a)
      GCON_ADDR:  reset_value = GCON_RST;
      R1_ADDR:    reset_value = R1_RST;
      P1_ADDR:    reset_value = P1_RST;
      S1_ADDR:    reset_value = S1_RST;
      R2_ADDR:    reset_value = R2_RST;
      P2_ADDR:    reset_value = P2_RST;
      S2_ADDR:    reset_value = S2_RST;
      FTPRI_ADDR: reset_value = FTPRI_RST;
      CLKO_ADDR:  reset_value = CLKO_RST;
      default:    reset_value = 8'h00;
    endcase
  endfunction

  // band index 0..3: 863-870, 902-915, 915-928, 950-960 MHz
  function automatic logic [1:0] band_code(input logic [1:0] idx);
    unique case (idx)
      2'h0: band_code = 2'h2;
      2'h1: band_code = 2'h0;
      2'h2: band_code = 2'h1;
      2'h3: band_code = 2'h2;
    endcase
  endfunction
endpackage

// [rsc_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface rsc_link_if;
  logic sck;          // serial clock, host driven
  logic csn;          // chip select, active low
  logic mosi;         // host to device data
  logic miso;         // device to host data
  logic rst_dev_o;    // device drive level on reset pin
  logic rst_dev_oe;   // device drives reset pin
  logic rst_host_o;   // host drive level on reset pin
  logic rst_host_oe;  // host drives reset pin
  logic rst_level;    // resolved reset pin level
  logic buffered_clock_out;       // buffered clock output
  logic lock_pin;     // lock indicator pin

  // undriven pin reads low through an assumed pull-down
  assign rst_level = (rst_dev_oe & rst_dev_o) | (rst_host_oe & rst_host_o);

  modport dev (
    input  sck, csn, mosi, rst_level,
    output miso, rst_dev_o, rst_dev_oe, buffered_clock_out, lock_pin
  );
  modport host (
    input  miso, rst_level, buffered_clock_out, lock_pin,
    output sck, csn, mosi, rst_host_o, rst_host_oe
  );
endinterface
`default_nettype wire

// [rsc_clk_div.sv]
`timescale 1ns/1ps
`default_nettype none
module rsc_clk_div (
  input  wire logic       i_mclk,   // reference clock
  input  wire logic       i_rst_n,  // sync reset, active low
  input  wire logic       i_ce,     // clock enable
  input  wire logic       i_run,    // output allowed to toggle
  input  wire logic [4:0] i_div,    // half period minus one
  output logic            o_clk     // divided clock
);
  logic [4:0] cnt_q, cnt_d;
  logic       clk_q, clk_d;

  // ratio is 2*(div+1); stopped output parks low
  always_comb begin
    cnt_d = cnt_q;
    clk_d = clk_q;
    if (!i_run) begin
      cnt_d = 5'h00;
      clk_d = 1'b0;                        // see RULE_16
    end else if (cnt_q >= i_div) begin
      cnt_d = 5'h00;
      clk_d = ~clk_q;                      // see RULE_06
    end else begin
      cnt_d = cnt_q + 5'h01;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      cnt_q <= 5'h00;
      clk_q <= 1'b0;
    end else if (i_ce) begin
      cnt_q <= cnt_d;
      clk_q <= clk_d;
    end
  end

  assign o_clk = clk_q;
endmodule
`default_nettype wire

// [rsc_device.sv]
`timescale 1ns/1ps
`default_nettype none
module rsc_device #(
  parameter int unsigned POR_CYC = rsc_pkg::DEV_POR_CYC
) (
  input  wire logic       i_mclk,          // crystal reference clock
  input  wire logic       i_rst_n,         // power-on reset, active low
  input  wire logic       i_ce,            // clock enable
  input  wire logic       i_pll_locked,    // synthesizer lock level
  rsc_link_if.dev         link,            // host link pins
  output logic            o_por_busy,      // power-on sequence running
  output logic            o_manual_reset,  // manual reset seen on pin
  output logic            o_tx_active,     // transmit mode selected
  output logic [2:0]      o_chip_mode,     // operating mode field
  output logic [1:0]      o_band_select,   // band select field
  output logic [1:0]      o_vco_trim       // vco trim field
);
  localparam int unsigned PW = $clog2(POR_CYC + 1);

  // ---------------------------------------------
  // state
  // ---------------------------------------------
  logic [31:0][7:0] regs_q, regs_d;
  logic [PW-1:0]    por_cnt_q, por_cnt_d;
  logic             por_q, por_d;
  logic             mrst_q, mrst_d;
  logic             lock_prev_q;
  logic             sck_prev_q;
  logic [4:0]       bit_q, bit_d;
  logic [7:0]       sh_q, sh_d;
  logic [4:0]       addr_q, addr_d;
  logic             rd_q, rd_d;
  logic [7:0]       out_q, out_d;
  logic             miso_q, miso_d;
  logic             lock_ind_q, lock_ind_d;
  logic             tx_q, tx_d;
  logic             clk_run;
  logic             sck_rise;
  logic             sck_fall;
  logic             lock_rise;
  logic [7:0]       byte_in;
  logic [7:0]       gcon;
  logic [7:0]       ftpri;
  logic [7:0]       clko;

  assign gcon      = regs_q[rsc_pkg::GCON_ADDR];
  assign ftpri     = regs_q[rsc_pkg::FTPRI_ADDR];
  assign clko      = regs_q[rsc_pkg::CLKO_ADDR];
  assign sck_rise  = link.sck & ~sck_prev_q;
  assign sck_fall  = ~link.sck & sck_prev_q;
  assign lock_rise = i_pll_locked & ~lock_prev_q;
  assign byte_in   = {sh_q[6:0], link.mosi};

  // ---------------------------------------------
  // power-on and manual reset
  // ---------------------------------------------
  // the pin is held high for the whole power-on sequence so that the
  // host can watch for its release; a high level afterwards is the host
  always_comb begin
    por_cnt_d = por_cnt_q;
    por_d     = por_q;
    mrst_d    = link.rst_level & ~por_q;
    if (por_q) begin
      if (por_cnt_q >= PW'(POR_CYC - 1)) begin
        por_d = 1'b0;                      // see RULE_04
      end else begin
        por_cnt_d = por_cnt_q + PW'(1);
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      por_cnt_q <= '0;
      por_q     <= 1'b1;
      mrst_q    <= 1'b0;
    end else if (i_ce) begin
      por_cnt_q <= por_cnt_d;
      por_q     <= por_d;
      mrst_q    <= mrst_d;
    end
  end

  // ---------------------------------------------
  // serial port
  // ---------------------------------------------
  // frame: {read, 2'b00, addr[4:0]} then one data byte, msb first;
  // bits are taken on the rising clock, read data shifts on falling
  always_comb begin
    bit_d  = bit_q;
    sh_d   = sh_q;
    addr_d = addr_q;
    rd_d   = rd_q;
    out_d  = out_q;
    miso_d = miso_q;
    if (link.csn) begin
      bit_d = 5'h00;
    end else if (sck_rise) begin
      sh_d  = byte_in;
      bit_d = bit_q + 5'h01;
      if (bit_q == 5'd7) begin
        rd_d   = sh_q[6];
        addr_d = byte_in[4:0];
        out_d  = regs_q[byte_in[4:0]];
      end
    end else if (sck_fall && bit_q >= 5'd8) begin
      miso_d = out_q[7];
      out_d  = {out_q[6:0], 1'b0};
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      sck_prev_q <= 1'b0;
      bit_q      <= 5'h00;
      sh_q       <= 8'h00;
      addr_q     <= 5'h00;
      rd_q       <= 1'b0;
      out_q      <= 8'h00;
      miso_q     <= 1'b0;
    end else if (i_ce) begin
      sck_prev_q <= link.sck;
      bit_q      <= bit_d;
      sh_q       <= sh_d;
      addr_q     <= addr_d;
      rd_q       <= rd_d;
      out_q      <= out_d;
      miso_q     <= miso_d;
    end
  end

  // ---------------------------------------------
  // register file
  // ---------------------------------------------
  always_comb begin
    regs_d = regs_q;
    if (por_q || mrst_q) begin
      for (int i = 0; i < 32; i++) begin
        regs_d[i] = rsc_pkg::reset_value(5'(i));  // see RULE_07
      end
    end else begin
      if (!link.csn && sck_rise && bit_q == 5'd15 && !rd_q) begin
        if (addr_q == rsc_pkg::FTPRI_ADDR) begin
          // the two lock bits clear on a written one
          regs_d[addr_q][7:2] = byte_in[7:2];
          if (byte_in[rsc_pkg::LOCK_STS]) begin
            regs_d[addr_q][rsc_pkg::LOCK_STS] = 1'b0;  // see RULE_08
          end
          if (byte_in[rsc_pkg::LOCK_PEN]) begin
            regs_d[addr_q][rsc_pkg::LOCK_PEN] = 1'b0;  // see RULE_10
          end
        end else begin
          regs_d[addr_q] = byte_in;
        end
      end
      // a lock in the clearing cycle is kept: set wins
      if (lock_rise) begin
        regs_d[rsc_pkg::FTPRI_ADDR][rsc_pkg::LOCK_STS] = 1'b1;  // see RULE_08
        regs_d[rsc_pkg::FTPRI_ADDR][rsc_pkg::LOCK_PEN] = 1'b1;  // see RULE_10
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      for (int i = 0; i < 32; i++) begin
        regs_q[i] <= rsc_pkg::reset_value(5'(i));
      end
      lock_prev_q <= 1'b0;
    end else if (i_ce) begin
      regs_q      <= regs_d;
      lock_prev_q <= i_pll_locked;
    end
  end

  // ---------------------------------------------
  // lock pin, mode decode
  // ---------------------------------------------
  always_comb begin
    lock_ind_d = i_pll_locked & ftpri[rsc_pkg::LOCK_PEN];  // see RULE_09
    tx_d       = (gcon[7:5] == rsc_pkg::MODE_TX);         // see RULE_15
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      lock_ind_q <= 1'b0;
      tx_q       <= 1'b0;
    end else if (i_ce) begin
      lock_ind_q <= lock_ind_d;
      tx_q       <= tx_d;
    end
  end

  // ---------------------------------------------
  // buffered clock output
  // ---------------------------------------------
  // the host may run from this clock, so sleep must be avoided by
  // software when the host has no clock of its own
  assign clk_run = clko[rsc_pkg::CLKEN_BIT]                 // see RULE_05
                 & (gcon[7:5] != rsc_pkg::MODE_SLEEP)       // see RULE_07
                 & ~por_q;

  rsc_clk_div u_div (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_run   (clk_run),
    .i_div   (clko[6:2]),                                   // see RULE_06
    .o_clk   (link.buffered_clock_out)
  );

  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  assign link.miso       = miso_q;
  assign link.rst_dev_o  = por_q;
  assign link.rst_dev_oe = por_q;                           // see RULE_04
  assign link.lock_pin   = lock_ind_q;
  assign o_por_busy      = por_q;
  assign o_manual_reset  = mrst_q;
  assign o_tx_active     = tx_q;
  assign o_chip_mode     = gcon[7:5];
  assign o_band_select   = gcon[4:3];
  assign o_vco_trim      = gcon[2:1];
endmodule
`default_nettype wire

// [rsc_host.sv]
`timescale 1ns/1ps
`default_nettype none
module rsc_host #(
  parameter int unsigned POR_WAIT  = rsc_pkg::POR_WAIT_CYC,
  parameter int unsigned MRST_WAIT = rsc_pkg::MRST_WAIT_CYC
) (
  input  wire logic       i_mclk,          // system clock
  input  wire logic       i_rst_n,         // sync reset, active low
  input  wire logic       i_ce,            // clock enable
  rsc_link_if.host        link,            // device link pins
  input  wire logic       i_req_valid,     // access request
  input  wire logic       i_req_read,      // 1 read, 0 write
  input  wire logic [4:0] i_req_addr,      // register offset
  input  wire logic [7:0] i_req_data,      // write data
  input  wire logic [1:0] i_band_idx,      // wanted band index
  input  wire logic       i_trim_step,     // raise vco trim one step
  input  wire logic       i_manual_reset,  // start manual reset
  output logic            o_req_ready,     // idle, request taken
  output logic            o_rsp_valid,     // read data pulse
  output logic [7:0]      o_rsp_data,      // read data
  output logic [1:0]      o_vco_trim       // trim last written
);
  localparam int unsigned MX0 = POR_WAIT > MRST_WAIT ? POR_WAIT : MRST_WAIT;
  localparam int unsigned MX  = MX0 > rsc_pkg::MRST_PULSE_CYC ?
                                MX0 : rsc_pkg::MRST_PULSE_CYC;
  localparam int unsigned CW  = $clog2(MX + 1);

  typedef enum logic [2:0] {
    H_POR, H_IDLE, H_XFER, H_MDRIVE, H_MWAIT
  } rsc_hst_e;

  rsc_hst_e    st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [15:0] frm_q, frm_d;
  logic [4:0]  bit_q, bit_d;
  logic        sck_q, sck_d, csn_q, csn_d, mosi_q, mosi_d;
  logic        rd_q, rd_d, oe_q, oe_d, rv_q, rv_d;
  logic [7:0]  rx_q, rx_d;
  logic [1:0]  trim_q, trim_d;
  logic [7:0]  gcon_q, gcon_d, p1_q, p1_d, p2_q, p2_d;
  logic [7:0]  wdat;

  // ---------------------------------------------
  // write data repair
  // ---------------------------------------------
  always_comb begin
    wdat = i_req_data;
    unique case (i_req_addr)
      rsc_pkg::R1_ADDR, rsc_pkg::R2_ADDR: begin
        if (wdat < rsc_pkg::R_MIN || wdat > rsc_pkg::R_MAX) begin
          wdat = rsc_pkg::R_RECOMMEND;     // see RULE_11 RULE_12
        end
      end
      rsc_pkg::S1_ADDR: wdat = (wdat > p1_q) ? p1_q : wdat;  // see RULE_11
      rsc_pkg::S2_ADDR: wdat = (wdat > p2_q) ? p2_q : wdat;  // see RULE_11
      rsc_pkg::GCON_ADDR: begin
        wdat[4:3] = rsc_pkg::band_code(i_band_idx);          // see RULE_13
        wdat[2:1] = trim_q;
      end
      default: wdat = i_req_data;
    endcase
  end

  // ---------------------------------------------
  // sequencer
  // ---------------------------------------------
  always_comb begin
    st_d = st_q; cnt_d = cnt_q; frm_d = frm_q; bit_d = bit_q;
    sck_d = sck_q; csn_d = csn_q; mosi_d = mosi_q; rd_d = rd_q;
    oe_d = 1'b0; rv_d = 1'b0; rx_d = rx_q; trim_d = trim_q;
    gcon_d = gcon_q; p1_d = p1_q; p2_d = p2_q;
    unique case (st_q)
      H_POR: begin
        // pin left alone; count from the release of the device's hold
        if (link.rst_level) begin
          cnt_d = '0;                                        // see RULE_02
        end else if (cnt_q >= CW'(POR_WAIT - 1)) begin
          st_d = H_IDLE;                                     // see RULE_01
        end else begin
          cnt_d = cnt_q + CW'(1);
        end
      end
      H_IDLE: begin
        cnt_d = '0;
        bit_d = 5'h00;
        if (i_manual_reset) begin
          st_d = H_MDRIVE;
          oe_d = 1'b1;
        end else if (i_trim_step && trim_q != 2'h3) begin
          trim_d = trim_q + 2'h1;                            // see RULE_14
          gcon_d = {gcon_q[7:3], trim_d, gcon_q[0]};
          frm_d  = {3'h0, rsc_pkg::GCON_ADDR, gcon_d};
          rd_d   = 1'b0;
          st_d   = H_XFER;
        end else if (i_req_valid) begin
          rd_d  = i_req_read;
          frm_d = {i_req_read, 2'h0, i_req_addr, wdat};
          st_d  = H_XFER;
          if (!i_req_read) begin
            if (i_req_addr == rsc_pkg::GCON_ADDR) gcon_d = wdat;
            if (i_req_addr == rsc_pkg::P1_ADDR) p1_d = wdat;
            if (i_req_addr == rsc_pkg::P2_ADDR) p2_d = wdat;
          end
        end
        if (st_d == H_XFER) begin
          csn_d  = 1'b0;
          mosi_d = frm_d[15];
          frm_d  = {frm_d[14:0], 1'b0};
        end
      end
      H_XFER: begin
        if (cnt_q >= CW'(rsc_pkg::SCK_HALF_CYC - 1)) begin
          cnt_d = '0;
          sck_d = ~sck_q;
          if (!sck_q) begin
            rx_d = {rx_q[6:0], link.miso};
          end else if (bit_q == 5'(rsc_pkg::FRAME_BITS - 1)) begin
            csn_d = 1'b1;
            rv_d  = rd_q;
            st_d  = H_IDLE;
          end else begin
            bit_d  = bit_q + 5'h01;
            mosi_d = frm_q[15];
            frm_d  = {frm_q[14:0], 1'b0};
          end
        end else begin
          cnt_d = cnt_q + CW'(1);
        end
      end
      H_MDRIVE: begin
        oe_d = 1'b1;
        if (cnt_q >= CW'(rsc_pkg::MRST_PULSE_CYC - 1)) begin
          oe_d  = 1'b0;                                      // see RULE_03
          cnt_d = '0;
          st_d  = H_MWAIT;
        end else begin
          cnt_d = cnt_q + CW'(1);
        end
      end
      H_MWAIT: begin
        // device registers, and so the trim, restart from defaults
        trim_d = rsc_pkg::TRIM_START;
        gcon_d = rsc_pkg::GCON_RST;
        p1_d   = rsc_pkg::P1_RST;
        p2_d   = rsc_pkg::P2_RST;
        if (cnt_q >= CW'(MRST_WAIT - 1)) begin
          st_d = H_IDLE;                                     // see RULE_03
        end else begin
          cnt_d = cnt_q + CW'(1);
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st_q <= H_POR; cnt_q <= '0; frm_q <= 16'h0000; bit_q <= 5'h00;
      sck_q <= 1'b0; csn_q <= 1'b1; mosi_q <= 1'b0; rd_q <= 1'b0;
      oe_q <= 1'b0; rv_q <= 1'b0; rx_q <= 8'h00;
      trim_q <= rsc_pkg::TRIM_START; gcon_q <= rsc_pkg::GCON_RST;
      p1_q <= rsc_pkg::P1_RST; p2_q <= rsc_pkg::P2_RST;
    end else if (i_ce) begin
      st_q <= st_d; cnt_q <= cnt_d; frm_q <= frm_d; bit_q <= bit_d;
      sck_q <= sck_d; csn_q <= csn_d; mosi_q <= mosi_d; rd_q <= rd_d;
      oe_q <= oe_d; rv_q <= rv_d; rx_q <= rx_d;
      trim_q <= trim_d; gcon_q <= gcon_d; p1_q <= p1_d; p2_q <= p2_d;
    end
  end

  assign link.sck         = sck_q;
  assign link.csn         = csn_q;
  assign link.mosi        = mosi_q;
  assign link.rst_host_o  = oe_q;
  assign link.rst_host_oe = oe_q;
  assign o_req_ready      = (st_q == H_IDLE) & ~i_manual_reset & ~i_trim_step;
  assign o_rsp_valid      = rv_q;
  assign o_rsp_data       = rx_q;
  assign o_vco_trim       = trim_q;
endmodule
`default_nettype wire

// [rsc_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module rsc_properties #(
  parameter int unsigned POR_WAIT  = 200,
  parameter int unsigned MRST_WAIT = 100
) (
  input wire logic i_mclk,       // reference clock
  input wire logic i_rst_n,      // sync reset, active low
  input wire logic csn,          // chip select, active low
  input wire logic rst_dev_o,    // device level on reset pin
  input wire logic rst_dev_oe,   // device drives reset pin
  input wire logic rst_host_oe,  // host drives reset pin
  input wire logic rst_level,    // resolved reset pin
  input wire logic buffered_clock_out        // buffered clock output
);
  // -------------------------------------------
  // helper counters
  // -------------------------------------------
  // 32-bit counts cannot wrap within any run this bench makes
  int unsigned quiet_q, quiet_d, hold_q, hold_d, high_q, high_d;
  logic        por_q, por_d;
  always_comb begin
    quiet_d = rst_level ? 0 : quiet_q + 1;
    hold_d  = rst_host_oe ? hold_q + 1 : 0;
    high_d  = buffered_clock_out ? high_q + 1 : 0;
    por_d   = rst_dev_oe | (por_q & ~rst_host_oe);
  end
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      quiet_q <= 0;
      hold_q  <= 0;
      high_q  <= 0;
      por_q   <= 1'b1;
    end else begin
      quiet_q <= quiet_d;
      hold_q  <= hold_d;
      high_q  <= high_d;
      por_q   <= por_d;
    end
  end
  // -------------------------------------------
  // properties
  // -------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence s_por_done;
    $fell(rst_dev_oe);
  endsequence
  sequence s_frame_start;
    $fell(csn);
  endsequence
  a_por_pin_high: assert property (rst_dev_oe |-> rst_dev_o)
    else $error("reset pin not driven high in power-on");
  a_host_pin_off: assert property (rst_dev_oe |-> !rst_host_oe)
    else $error("host drives reset pin in power-on");
  a_no_link_pin: assert property (rst_level |-> csn)
    else $error("link access while reset pin high");
  a_por_link_wait: assert property
    (s_frame_start |-> !por_q || quiet_q >= POR_WAIT)
    else $error("link access too soon after power-on");
  a_mrst_link_wait: assert property
    (s_frame_start |-> quiet_q >= MRST_WAIT)
    else $error("link access too soon after manual reset");
  a_mrst_pulse_len: assert property
    ($fell(rst_host_oe) |-> hold_q == rsc_pkg::MRST_PULSE_CYC)
    else $error("manual reset pulse length wrong");
  a_clk_quiet_por: assert property (rst_dev_oe |-> !buffered_clock_out)
    else $error("clock output runs during power-on");
  a_clk_start_up: assert property
    (s_por_done |-> ##[1:40] $rose(buffered_clock_out))
    else $error("clock output not started after power-on");
  a_clk_half_max: assert property
    ($fell(buffered_clock_out) |-> high_q inside {[1:32]})
    else $error("clock output high phase too long");
endmodule
`default_nettype wire

// [rf_synth_reset_clock_control_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module rf_synth_reset_clock_control_tb;
  localparam logic [7:0]  BANDS = {2'h2, 2'h1, 2'h0, 2'h2};
  localparam logic [31:0] CORN  = 32'h3F40A9AA;
  logic        i_mclk = 0, i_rst_n = 0, locked = 0, tx, rv, rdy;
  logic        vld = 0, rd = 0, step = 0, mrst = 0, ce = 1, pb, mr;
  logic [4:0]  addr = 0;
  logic [7:0]  wdat = 0, rdat, got, v;
  logic [1:0]  band = 0, bs, trim_d, trim_h;
  logic [2:0]  mode;
  logic [16:0] lf = 17'h172BD;
  int          miscompares = 0, tests_run = 0, n, h;
  rsc_link_if link ();
  always #12.5 i_mclk = ~i_mclk;
  rsc_device #(.POR_CYC(20)) rsc_device_inst (.i_mclk(i_mclk),
    .i_rst_n(i_rst_n), .i_ce(ce), .i_pll_locked(locked), .link(link),
    .o_por_busy(pb), .o_manual_reset(mr), .o_tx_active(tx), .o_chip_mode(mode),
    .o_band_select(bs), .o_vco_trim(trim_d));
  rsc_host #(.POR_WAIT(200), .MRST_WAIT(100)) rsc_host_inst (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(ce), .link(link),
    .i_req_valid(vld), .i_req_read(rd), .i_req_addr(addr),
    .i_req_data(wdat), .i_band_idx(band), .i_trim_step(step),
    .i_manual_reset(mrst), .o_req_ready(rdy), .o_rsp_valid(rv),
    .o_rsp_data(rdat), .o_vco_trim(trim_h));
  rsc_properties #(.POR_WAIT(200), .MRST_WAIT(100)) rsc_properties_inst (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .csn(link.csn),
    .rst_dev_o(link.rst_dev_o), .rst_dev_oe(link.rst_dev_oe),
    .rst_host_oe(link.rst_host_oe), .rst_level(link.rst_level),
    .buffered_clock_out(link.buffered_clock_out));
  function automatic logic [7:0] fix_r(input logic [7:0] x);
    return (x < 8'h40 || x > 8'hA9) ? 8'h77 : x;
  endfunction
  function automatic logic [16:0] nxt(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  task automatic tick();
    @(posedge i_mclk);
    #1;
  endtask
  task automatic wt();
    n = 0;
    do begin tick(); n++; if (rv) got = rdat; end while (!rdy && n < 9000);
  endtask
  task automatic acc(input logic r, input logic [4:0] a,
                     input logic [7:0] d);
    wt();
    rd = r;
    addr = a;
    wdat = d;
    vld = 1;
    tick();
    vld = 0;
    wt();
  endtask
  // high phase in reference cycles, 0 when the output stays low
  task automatic half();
    h = 0;
    for (n = 0; n < 200 && link.buffered_clock_out; n++) tick();
    for (n = 0; n < 200 && !link.buffered_clock_out; n++) tick();
    for (n = 0; n < 200 && link.buffered_clock_out; n++) begin tick(); h++; end
  endtask
  task automatic stop_test();
    if (miscompares == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge i_mclk);
    miscompares++;
    stop_test();
  end
  initial begin
    repeat (20) @(posedge i_mclk);
    #1;
    `CHK(pb, 1'b1)
    i_rst_n = 1;
    acc(1, rsc_pkg::R1_ADDR, 8'h00);
    `CHK(got, rsc_pkg::R1_RST)
    half();
    `CHK(h, 16)
    // a frozen enable must stretch the high phase by the freeze length
    while (!link.buffered_clock_out) tick();
    ce = 0;
    repeat (12) tick();
    ce = 1;
    for (n = 0; link.buffered_clock_out; n++) tick();
    `CHK(n, int'(rsc_pkg::CLKO_RST[6:2]) + 1)
    for (int i = 0; i < 8; i++) begin
      v = (i < 4) ? CORN[i*8 +: 8] : lf[7:0];
      lf = nxt(lf);
      acc(0, rsc_pkg::R1_ADDR, v);
      acc(1, rsc_pkg::R1_ADDR, 8'h00);
      `CHK(got, fix_r(v))
    end
    for (int i = 0; i < 4; i++) begin
      band = 2'(i);
      acc(0, rsc_pkg::GCON_ADDR, 8'h80);
      tick();
      `CHK(bs, BANDS[i*2 +: 2])
      `CHK(tx, 1'b1)
    end
    for (int i = 1; i < 5; i++) begin
      step = 1;
      tick();
      step = 0;
      wt();
      `CHK(trim_d, 2'((i < 4) ? i : 3))
      `CHK(trim_h, 2'((i < 4) ? i : 3))
    end
    acc(0, rsc_pkg::S1_ADDR, 8'hFF);
    acc(1, rsc_pkg::S1_ADDR, 8'h00);
    `CHK(got, rsc_pkg::P1_RST)
    locked = 1;
    acc(1, rsc_pkg::FTPRI_ADDR, 8'h00);
    `CHK(got[1:0], 2'h3)
    `CHK(link.lock_pin, 1'b1)
    acc(0, rsc_pkg::FTPRI_ADDR, 8'h02);
    acc(1, rsc_pkg::FTPRI_ADDR, 8'h00);
    `CHK(got[1:0], 2'h1)
    acc(0, rsc_pkg::FTPRI_ADDR, 8'h01);
    tick();
    `CHK(link.lock_pin, 1'b0)
    locked = 0;
    tick();
    locked = 1;
    acc(1, rsc_pkg::FTPRI_ADDR, 8'h00);
    `CHK(got[1:0], 2'h3)
    acc(0, rsc_pkg::CLKO_ADDR, 8'h3C);
    half();
    `CHK(h, 0)
    v = {1'b1, lf[4:0], 2'h0};
    acc(0, rsc_pkg::CLKO_ADDR, v);
    half();
    `CHK(h, int'(v[6:2]) + 1)
    acc(0, rsc_pkg::GCON_ADDR, 8'h00);
    half();
    `CHK(h, 0)
    mrst = 1;
    tick();
    mrst = 0;
    tick();
    `CHK(mr, 1'b1)
    acc(1, rsc_pkg::R1_ADDR, 8'h00);
    `CHK(got, rsc_pkg::R1_RST)
    `CHK(trim_h, rsc_pkg::TRIM_START)
    `CHK(mode, rsc_pkg::GCON_RST[7:5])
    stop_test();
  end
endmodule
`default_nettype wire
